// file: rtl/pin_sync.sv
/*
 Two-stage synchroniser for a vector of asynchronous pins.
 Assumes each bit is an independent level; no bus coherence is given.
*/
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 11,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;

   // First stage feeds only the second
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stage1 <= RESET_VALUE;
         sync_out <= RESET_VALUE;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule
`default_nettype wire

// file: rtl/remote_upgrade_pkg.sv
/*
 Shared constants, field layouts and types of the remote upgrade status
 and reconfiguration sequencer.
 Assumes a single 250 MHz core clock; all user and pin timing is sampled.
*/
`default_nettype none
package remote_upgrade_pkg;
   // Core clock and strobe timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int CORE_STROBE_MIN_NS = 250;
   localparam int CORE_STROBE_MIN_CYC = (CORE_STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Widths
   localparam int CTRL_W = 38;
   localparam int STATUS_W = 32;
   localparam int PREV_W = 31;
   localparam int SRC_W = 5;
   localparam int BOOT_W = 24;
   localparam int WD_COUNT_W = 29;
   localparam int SYNC_W = 11;
   // Fixed fills that widen short fields
   localparam logic [16:0] WD_SUFFIX = 17'h00008;
   localparam logic [1:0] BOOT_PAD = 2'h0;
   localparam logic [5:0] STATUS_PAD = 6'h00;
   // Master state codes
   localparam logic [1:0] MASTER_FACTORY = 2'h0;
   localparam logic [1:0] MASTER_APP = 2'h1;
   // One-hot source field positions, higher position wins a tie
   localparam int SRC_EXT = 4;
   localparam int SRC_CRC = 3;
   localparam int SRC_ERR = 2;
   localparam int SRC_WD = 1;
   localparam int SRC_CORE = 0;
   localparam logic [4:0] SRC_CORE_HOT = 5'h01;
   // All-ones source field can never be one-hot
   localparam logic [30:0] INVALID_CAPTURE = 31'h7fffffff;
   // Capture selections
   localparam logic [2:0] SEL_CURRENT = 3'h0;
   localparam logic [2:0] SEL_APP2 = 3'h1;
   localparam logic [2:0] SEL_PREV1 = 3'h2;
   localparam logic [2:0] SEL_PREV2 = 3'h3;
   localparam logic [2:0] SEL_CTRL = 3'h4;
   // Synchroniser reset image: active-low pins idle high
   localparam logic [10:0] SYNC_RESET = 11'h600;

   typedef struct packed {
      logic early_done_check;
      logic startup_osc_select;
      logic watchdog_enable_bit;
      logic reserved;
      logic [21:0] boot_address_field;
      logic [11:0] watchdog_timeout_field;
   } ctrl_word_s;

   typedef struct packed {
      logic [4:0] source;
      logic [1:0] master;
      logic [23:0] boot_address;
   } prev_record_s;

   typedef struct packed {
      logic error_status_pin_n;
      logic external_config_reset_n;
      logic core_reconfig_strobe;
      logic upgrade_shift_clock;
      logic shift_data_in;
      logic shift_enable;
      logic capture_enable;
      logic update_enable;
      logic [2:0] capture_sel;
   } pins_s;

   typedef enum logic [1:0] {
      seq_run = 2'h0,
      seq_record = 2'h1,
      seq_reload = 2'h3
   } seq_e;
endpackage
`default_nettype wire

// file: rtl/remote_upgrade_status_and_sm.sv
/*
 Status recording and reconfiguration sequencer of the remote upgrade block.
 Assumes pins arrive asynchronously; crc_error and watchdog_timeout are
 same-clock pulses from neighbouring logic.
*/
// Overview of operation
// RQ1: Record cause of every reconfiguration.
// RQ2: Current-state word is 32 bits, mode dependent.
// RQ3: Factory word: state, zero pad, boot address.
// RQ4: App word one: state, enable, watchdog count.
// RQ5: App word two: state, zero pad, address.
// RQ6: Two previous records, newest then older.
// RQ7: One-hot source field at bits 30:26.
// RQ8: Simultaneous sources: highest bit wins.
// RQ9: Records hold master state and boot address.
// RQ10: Early previous capture returns invalid marker.
// RQ11: Update register writable only in factory.
// RQ12: User loads update register before triggering.
// RQ13: Core strobe rise copies update to control.
// RQ14: User holds core strobe at least 250 ns.
// RQ15: Events select factory or application load.
// RQ16: Errors clear control; core trigger copies update.
// RQ17: Status written before the new load begins.
// RQ18: Control layout: timer, address, option bits.
// RQ19: Widen timer and address by fixed suffixes.
// RQ20: Shift path on user clock, control internal.
// RQ21: Invalid marker cannot match any legal record.
`default_nettype none
module remote_upgrade_status_and_sm (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic error_status_pin_n,
   input wire logic external_config_reset_n,
   input wire logic core_reconfig_strobe,
   input wire logic crc_error,
   input wire logic watchdog_timeout,
   input wire logic upgrade_shift_clock,
   input wire logic shift_data_in,
   input wire logic shift_enable,
   input wire logic capture_enable,
   input wire logic update_enable,
   input wire logic [2:0] capture_sel,
   output logic shift_data_out,
   output remote_upgrade_pkg::ctrl_word_s control_word,
   output logic [1:0] master_state,
   output logic [23:0] boot_address,
   output logic [28:0] watchdog_count,
   output logic watchdog_enable,
   output logic reconfig_start
);
   remote_upgrade_pkg::pins_s pins_raw;
   remote_upgrade_pkg::pins_s pins;
   remote_upgrade_pkg::pins_s pins_d;
   remote_upgrade_pkg::ctrl_word_s update_word;
   remote_upgrade_pkg::ctrl_word_s shift_as_ctrl;
   remote_upgrade_pkg::prev_record_s prev_one;
   remote_upgrade_pkg::prev_record_s prev_two;
   remote_upgrade_pkg::seq_e seq;
   logic [4:0] raw_src;
   logic [4:0] next_src;
   logic [4:0] pending_src;
   logic [37:0] sr_word;
   logic [37:0] capture_word;
   logic [31:0] current_word;
   logic [31:0] app_two_word;
   logic tick;
   logic ext_evt;
   logic err_evt;
   logic core_evt;
   logic any_evt;
   logic entered_app;
   logic in_factory;

   assign pins_raw = {error_status_pin_n, external_config_reset_n, core_reconfig_strobe, upgrade_shift_clock,
                      shift_data_in, shift_enable, capture_enable, update_enable, capture_sel};

   // All user pins pass two flops before any logic
   pin_sync #(
      .WIDTH(remote_upgrade_pkg::SYNC_W),
      .RESET_VALUE(remote_upgrade_pkg::SYNC_RESET)
   ) u_sync (
      .clk(clk),
      .reset_n(reset_n),
      .async_in(pins_raw),
      .sync_out(pins)
   );

   // Delayed copy for edge detection
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pins_d <= remote_upgrade_pkg::SYNC_RESET;
      end else begin
         pins_d <= pins;
      end
   end

   // User shift clock edge; it must stay well below half the core rate
   assign tick = pins.upgrade_shift_clock && !pins_d.upgrade_shift_clock; // RQ20

   // Trigger edges: active-low pins on falling, core strobe on rising
   assign ext_evt = pins_d.external_config_reset_n && !pins.external_config_reset_n;
   assign err_evt = pins_d.error_status_pin_n && !pins.error_status_pin_n;
   assign core_evt = pins.core_reconfig_strobe && !pins_d.core_reconfig_strobe; // RQ13
   assign in_factory = (master_state == remote_upgrade_pkg::MASTER_FACTORY);

   // Recognised causes gathered in field order
   always_comb begin
      raw_src = '0;
      raw_src[remote_upgrade_pkg::SRC_EXT] = ext_evt; // RQ1
      raw_src[remote_upgrade_pkg::SRC_CRC] = crc_error;
      raw_src[remote_upgrade_pkg::SRC_ERR] = err_evt;
      raw_src[remote_upgrade_pkg::SRC_WD] = watchdog_timeout;
      raw_src[remote_upgrade_pkg::SRC_CORE] = core_evt;
   end
   assign any_evt = |raw_src;

   // Keep only the highest set position so the field stays one-hot
   always_comb begin
      next_src = '0;
      for (int i = 0; i < remote_upgrade_pkg::SRC_W; i++) begin
         if (raw_src[i]) begin
            next_src = 5'h01 << i; // RQ8
         end
      end
   end

   // Sequencer: run, record status, then reload control
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         seq <= remote_upgrade_pkg::seq_run;
      end else begin
         unique case (seq)
            remote_upgrade_pkg::seq_run: begin
               if (any_evt) begin
                  seq <= remote_upgrade_pkg::seq_record;
               end
            end
            remote_upgrade_pkg::seq_record: begin
               seq <= remote_upgrade_pkg::seq_reload; // RQ17
            end
            remote_upgrade_pkg::seq_reload: begin
               seq <= remote_upgrade_pkg::seq_run;
            end
            default: begin
               seq <= remote_upgrade_pkg::seq_run;
            end
         endcase
      end
   end

   // Cause latched on entry; events inside the sequence are dropped
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pending_src <= '0;
      end else if (seq == remote_upgrade_pkg::seq_run && any_evt) begin
         pending_src <= next_src; // RQ1
      end
   end

   // Previous records age by one on every reconfiguration
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prev_one <= '0;
         prev_two <= '0;
      end else if (seq == remote_upgrade_pkg::seq_record) begin
         prev_two <= prev_one; // RQ6
         prev_one.source <= pending_src; // RQ7
         prev_one.master <= master_state; // RQ9
         prev_one.boot_address <= boot_address;
      end
   end

   // Control word chosen from the cause
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         control_word <= '0;
         master_state <= remote_upgrade_pkg::MASTER_FACTORY;
      end else if (seq == remote_upgrade_pkg::seq_reload) begin
         if (pending_src == remote_upgrade_pkg::SRC_CORE_HOT) begin
            control_word <= update_word; // RQ13
            master_state <= remote_upgrade_pkg::MASTER_APP; // RQ15
         end else begin
            control_word <= '0; // RQ16
            master_state <= remote_upgrade_pkg::MASTER_FACTORY;
         end
      end
   end

   // One-cycle start toward the configuration controller
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         reconfig_start <= 1'b0;
      end else begin
         reconfig_start <= (seq == remote_upgrade_pkg::seq_reload); // RQ15
      end
   end

   // Previous records hold no meaning until an application ran
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         entered_app <= 1'b0;
      end else if (master_state == remote_upgrade_pkg::MASTER_APP) begin
         entered_app <= 1'b1;
      end
   end

   // Widened views of the control fields
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         boot_address <= '0;
         watchdog_count <= '0;
         watchdog_enable <= 1'b0;
      end else begin
         boot_address <= {control_word.boot_address_field, remote_upgrade_pkg::BOOT_PAD}; // RQ19
         watchdog_count <= {control_word.watchdog_timeout_field, remote_upgrade_pkg::WD_SUFFIX}; // RQ19
         watchdog_enable <= control_word.watchdog_enable_bit; // RQ18
      end
   end

   // Reserved control bit never stores a one
   always_comb begin
      shift_as_ctrl = sr_word; // RQ18
      shift_as_ctrl.reserved = 1'b0;
   end

   // Update register accepts writes only under a factory image
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         update_word <= '0;
      end else if (tick && pins.update_enable && in_factory) begin
         update_word <= shift_as_ctrl; // RQ11
      end
   end

   // Current-state words, meaning set by the master state
   always_comb begin
      app_two_word = {master_state, remote_upgrade_pkg::STATUS_PAD, boot_address}; // RQ5
      if (in_factory) begin
         current_word = {master_state, remote_upgrade_pkg::STATUS_PAD, boot_address}; // RQ3
      end else begin
         current_word = {master_state, watchdog_enable, watchdog_count}; // RQ4
      end
   end

   // Capture source; narrow words sit in the low bits
   always_comb begin
      capture_word = '0;
      unique case (pins.capture_sel)
         remote_upgrade_pkg::SEL_CURRENT: capture_word = {6'h00, current_word}; // RQ2
         remote_upgrade_pkg::SEL_APP2: capture_word = {6'h00, app_two_word};
         remote_upgrade_pkg::SEL_PREV1: begin
            capture_word = entered_app ? {7'h00, prev_one} : {7'h00, remote_upgrade_pkg::INVALID_CAPTURE}; // RQ10
         end
         remote_upgrade_pkg::SEL_PREV2: begin
            capture_word = entered_app ? {7'h00, prev_two} : {7'h00, remote_upgrade_pkg::INVALID_CAPTURE}; // RQ21
         end
         remote_upgrade_pkg::SEL_CTRL: capture_word = in_factory ? update_word : control_word;
         default: capture_word = '0;
      endcase
   end

   // Shift path to user logic
   upgrade_shift #(
      .WIDTH(remote_upgrade_pkg::CTRL_W)
   ) u_shift (
      .clk(clk),
      .reset_n(reset_n),
      .tick(tick),
      .load(pins.capture_enable),
      .shift(pins.shift_enable),
      .load_word(capture_word),
      .serial_in(pins.shift_data_in),
      .word(sr_word),
      .serial_out(shift_data_out)
   );

   // Checks next to the sequencer
   property p_onehot_record;
      @(posedge clk) disable iff (!reset_n)
      seq == remote_upgrade_pkg::seq_record |-> $onehot(pending_src);
   endproperty
   a_onehot_record: assert property (p_onehot_record) else $error("source not one-hot"); // RQ7

   property p_priority;
      @(posedge clk) disable iff (!reset_n)
      seq == remote_upgrade_pkg::seq_run && ext_evt && core_evt |=> pending_src == 5'h10;
   endproperty
   a_priority: assert property (p_priority) else $error("config reset lost priority"); // RQ8

   property p_record_order;
      @(posedge clk) disable iff (!reset_n)
      seq == remote_upgrade_pkg::seq_run && any_evt |=> seq == remote_upgrade_pkg::seq_record
         ##1 seq == remote_upgrade_pkg::seq_reload ##1 reconfig_start && seq == remote_upgrade_pkg::seq_run;
   endproperty
   a_record_order: assert property (p_record_order) else $error("record not before reload"); // RQ17

   property p_record_fields;
      @(posedge clk) disable iff (!reset_n)
      seq == remote_upgrade_pkg::seq_record |=>
         prev_one.source == $past(pending_src) && prev_one.master == $past(master_state)
         && prev_one.boot_address == $past(boot_address);
   endproperty
   a_record_fields: assert property (p_record_fields) else $error("record fields wrong"); // RQ9

   property p_aging;
      @(posedge clk) disable iff (!reset_n)
      seq == remote_upgrade_pkg::seq_record |=> prev_two == $past(prev_one);
   endproperty
   a_aging: assert property (p_aging) else $error("older record not aged"); // RQ6

   property p_error_clear;
      @(posedge clk) disable iff (!reset_n)
      seq == remote_upgrade_pkg::seq_reload && pending_src != remote_upgrade_pkg::SRC_CORE_HOT
         |=> control_word == '0 && master_state == remote_upgrade_pkg::MASTER_FACTORY;
   endproperty
   a_error_clear: assert property (p_error_clear) else $error("control not cleared"); // RQ16

   property p_core_copy;
      @(posedge clk) disable iff (!reset_n)
      seq == remote_upgrade_pkg::seq_reload && pending_src == remote_upgrade_pkg::SRC_CORE_HOT
         |=> control_word == $past(update_word) ##1 boot_address[1:0] == 2'h0;
   endproperty
   a_core_copy: assert property (p_core_copy) else $error("update not copied"); // RQ13

   property p_update_lock;
      @(posedge clk) disable iff (!reset_n)
      $changed(update_word) |-> $past(in_factory) && $past(tick);
   endproperty
   a_update_lock: assert property (p_update_lock) else $error("update written outside factory"); // RQ11

   property p_invalid;
      @(posedge clk) disable iff (!reset_n)
      tick && pins.capture_enable && pins.capture_sel == remote_upgrade_pkg::SEL_PREV1 && !entered_app
         |=> sr_word[30:0] == remote_upgrade_pkg::INVALID_CAPTURE;
   endproperty
   a_invalid: assert property (p_invalid) else $error("early capture not marked"); // RQ10

   property p_factory_pad;
      @(posedge clk) disable iff (!reset_n)
      in_factory |-> current_word[29:24] == 6'h00 && current_word[23:0] == boot_address;
   endproperty
   a_factory_pad: assert property (p_factory_pad) else $error("factory word layout"); // RQ3

   property p_watchdog_view;
      @(posedge clk) disable iff (!reset_n)
      $changed(control_word) |=> watchdog_count[16:0] == 17'h00008
         && watchdog_count[28:17] == $past(control_word.watchdog_timeout_field);
   endproperty
   a_watchdog_view: assert property (p_watchdog_view) else $error("watchdog count wrong"); // RQ19

   property p_cov_core;
      @(posedge clk) disable iff (!reset_n)
      core_evt && in_factory ##3 master_state == remote_upgrade_pkg::MASTER_APP;
   endproperty
   c_cov_core: cover property (p_cov_core);

   property p_cov_wd;
      @(posedge clk) disable iff (!reset_n)
      seq == remote_upgrade_pkg::seq_record && pending_src[remote_upgrade_pkg::SRC_WD];
   endproperty
   c_cov_wd: cover property (p_cov_wd);

   property p_cov_update;
      @(posedge clk) disable iff (!reset_n)
      tick && pins.update_enable && in_factory;
   endproperty
   c_cov_update: cover property (p_cov_update);
endmodule
`default_nettype wire

// file: rtl/upgrade_shift.sv
/*
 Shift register between user logic and the upgrade registers.
 Assumes the caller gives a one-cycle tick per user shift clock rising edge.
*/
`default_nettype none
module upgrade_shift #(
   parameter int WIDTH = 38
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic tick,
   input wire logic load,
   input wire logic shift,
   input wire logic [WIDTH-1:0] load_word,
   input wire logic serial_in,
   output logic [WIDTH-1:0] word,
   output logic serial_out
);
   // Load beats shift so a capture is never half shifted
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         word <= '0;
      end else if (tick && load) begin
         word <= load_word;
      end else if (tick && shift) begin
         word <= {serial_in, word[WIDTH-1:1]};
      end
   end

   // Least significant bit leaves first
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         serial_out <= 1'b0;
      end else begin
         serial_out <= word[0];
      end
   end
endmodule
`default_nettype wire

// file: testbench/remote_upgrade_status_and_sm_tb.sv
/*
 Self-checking bench of the status recorder and reconfiguration sequencer.
 Assumes the user logic model drives the shift path and core strobe.
*/
`default_nettype none
module remote_upgrade_status_and_sm_tb;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic [37:0] ctrl;
      logic [1:0] master;
   } note_s;

   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic error_status_pin_n = 1'b1;
   logic external_config_reset_n = 1'b1;
   logic crc_error = 1'b0;
   logic watchdog_timeout = 1'b0;
   logic upgrade_shift_clock, shift_data_in, shift_enable, capture_enable, update_enable;
   logic core_reconfig_strobe, shift_data_out, watchdog_enable, reconfig_start;
   logic [2:0] capture_sel;
   remote_upgrade_pkg::ctrl_word_s control_word;
   logic [1:0] master_state;
   logic [23:0] boot_address;
   logic [28:0] watchdog_count;
   logic [37:0] upd, exp, w;
   logic [4:0] src_hot [4] = '{5'h08, 5'h02, 5'h04, 5'h10};
   note_s notes [$];
   note_s n;
   int mismatches = 0;
   int check_count = 0;

   always #2 clk = ~clk;

   remote_upgrade_status_and_sm u_remote_upgrade_status_and_sm (.clk(clk), .reset_n(reset_n),
      .error_status_pin_n(error_status_pin_n), .external_config_reset_n(external_config_reset_n),
      .core_reconfig_strobe(core_reconfig_strobe), .crc_error(crc_error), .watchdog_timeout(watchdog_timeout),
      .upgrade_shift_clock(upgrade_shift_clock), .shift_data_in(shift_data_in), .shift_enable(shift_enable),
      .capture_enable(capture_enable), .update_enable(update_enable), .capture_sel(capture_sel),
      .shift_data_out(shift_data_out), .control_word(control_word), .master_state(master_state),
      .boot_address(boot_address), .watchdog_count(watchdog_count), .watchdog_enable(watchdog_enable),
      .reconfig_start(reconfig_start));

   user_logic_model u_user_logic_model (.clk(clk), .shift_data_out(shift_data_out),
      .upgrade_shift_clock(upgrade_shift_clock), .shift_data_in(shift_data_in), .shift_enable(shift_enable),
      .capture_enable(capture_enable), .update_enable(update_enable), .capture_sel(capture_sel),
      .core_reconfig_strobe(core_reconfig_strobe));

   task automatic check(input string name, input logic [37:0] seen, input logic [37:0] expv);
      check_count++;
      if (seen !== expv) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", name, expv, seen);
      end
   endtask

   task automatic report_and_stop();
      if (mismatches == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Bounded wait for the start pulse, then the sequencer's recovery gap
   task automatic wait_start();
      int i;
      for (i = 0; i < 80 && reconfig_start !== 1'b1; i++) @(posedge clk);
      if (i == 80) begin
         mismatches++;
         report_and_stop();
      end
      repeat (6) @(posedge clk);
   endtask

   task automatic read_check(input string name, input logic [2:0] sel, input int nb, input logic [37:0] expv);
      u_user_logic_model.read_word(sel, nb, w);
      check(name, w, expv);
   endtask

   // Each start pulse consumes the oldest note; derived outputs land one clock later
   always @(posedge clk) begin
      if (reconfig_start === 1'b1) begin
         if (notes.size() == 0) begin
            check("reconfig_start", 38'h1, 38'h0);
         end else begin
            n = notes.pop_front();
            check("control_word", control_word, n.ctrl);
            check("master_state", 38'(master_state), 38'(n.master));
            @(posedge clk);
            check("boot_address", 38'(boot_address), 38'({n.ctrl[33:12], 2'h0}));
            check("watchdog_count", 38'(watchdog_count), 38'({n.ctrl[11:0], 17'h00008}));
            check("watchdog_enable", 38'(watchdog_enable), 38'(n.ctrl[35]));
         end
      end
   end

   initial begin
      void'($urandom(32'h37f9));
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      // Factory word after reset, and previous records before any application
      read_check("factory word", remote_upgrade_pkg::SEL_CURRENT, 32, 38'h0);
      read_check("early prev one", remote_upgrade_pkg::SEL_PREV1, 31, 38'(remote_upgrade_pkg::INVALID_CAPTURE));
      read_check("early prev two", remote_upgrade_pkg::SEL_PREV2, 31, 38'(remote_upgrade_pkg::INVALID_CAPTURE));
      // Random update word; the reserved bit is never stored
      upd = 38'({$urandom(), $urandom()});
      exp = upd;
      exp[34] = 1'b0;
      u_user_logic_model.write_update(upd);
      read_check("update reg", remote_upgrade_pkg::SEL_CTRL, 38, exp);
      notes.push_back({exp, remote_upgrade_pkg::MASTER_APP});
      fork
         u_user_logic_model.pulse_strobe();
      join_none
      wait_start();
      repeat (70) @(posedge clk);
      // Application words and the first record
      read_check("app word one", remote_upgrade_pkg::SEL_CURRENT, 32, 38'({2'h1, exp[35], exp[11:0], 17'h00008}));
      read_check("app word two", remote_upgrade_pkg::SEL_APP2, 32, 38'({2'h1, 6'h0, exp[33:12], 2'h0}));
      read_check("prev one", remote_upgrade_pkg::SEL_PREV1, 31, 38'({5'h01, 2'h0, 24'h0}));
      // Update write refused in application; a second trigger reloads the old word
      u_user_logic_model.write_update(~upd);
      read_check("control reg", remote_upgrade_pkg::SEL_CTRL, 38, exp);
      notes.push_back({exp, remote_upgrade_pkg::MASTER_APP});
      fork
         u_user_logic_model.pulse_strobe();
      join_none
      wait_start();
      repeat (70) @(posedge clk);
      read_check("aged prev two", remote_upgrade_pkg::SEL_PREV2, 31, 38'({5'h01, 2'h0, 24'h0}));
      // Error causes and ties; the higher source position must win
      for (int k = 0; k < 4; k++) begin
         notes.push_back({38'h0, remote_upgrade_pkg::MASTER_FACTORY});
         fork
            if (k == 3) u_user_logic_model.pulse_strobe();
         join_none
         @(posedge clk);
         crc_error <= (k == 0);
         watchdog_timeout <= (k < 2);
         error_status_pin_n <= (k != 2);
         external_config_reset_n <= (k != 3);
         @(posedge clk);
         crc_error <= 1'b0;
         watchdog_timeout <= 1'b0;
         // Start comes 3 to 5 clocks on, so watch now; pins stay low until it is seen
         wait_start();
         error_status_pin_n <= 1'b1;
         external_config_reset_n <= 1'b1;
         repeat (70) @(posedge clk);
         read_check("source record", remote_upgrade_pkg::SEL_PREV1, 31,
            38'({src_hot[k], (k == 0) ? 2'h1 : 2'h0, (k == 0) ? {exp[33:12], 2'h0} : 24'h0}));
      end
      check("pending notes", 38'(notes.size()), 38'h0);
      report_and_stop();
   end
endmodule
`default_nettype wire

// file: testbench/user_logic_model.sv
/*
 Model of the user logic in the logic array driving the upgrade shift path.
 Assumes a free-running core clock; every pin moves just after its edge.
*/
`default_nettype none
module user_logic_model (
   input wire logic clk,
   input wire logic shift_data_out,
   output logic upgrade_shift_clock,
   output logic shift_data_in,
   output logic shift_enable,
   output logic capture_enable,
   output logic update_enable,
   output logic [2:0] capture_sel,
   output logic core_reconfig_strobe
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle levels; shift clock stands low outside transfers
   initial begin
      upgrade_shift_clock = 1'b0;
      shift_data_in = 1'b0;
      shift_enable = 1'b0;
      capture_enable = 1'b0;
      update_enable = 1'b0;
      capture_sel = 3'h0;
      core_reconfig_strobe = 1'b0;
   end

   // One shift clock period; controls settle before the rise crosses the sync
   task automatic tick(input logic cap, input logic sh, input logic upd, input logic din);
      @(posedge clk);
      capture_enable <= cap;
      shift_enable <= sh;
      update_enable <= upd;
      shift_data_in <= din;
      repeat (4) @(posedge clk);
      upgrade_shift_clock <= 1'b1;
      repeat (4) @(posedge clk);
      upgrade_shift_clock <= 1'b0;
      repeat (4) @(posedge clk);
      capture_enable <= 1'b0;
      shift_enable <= 1'b0;
      update_enable <= 1'b0;
      shift_data_in <= ~din; // Released line must not keep the last bit
   endtask

   // Capture a word, then read it LSB first
   task automatic read_word(input logic [2:0] sel, input int n, output logic [37:0] w);
      w = '0;
      @(posedge clk);
      capture_sel <= sel;
      tick(1'b1, 1'b0, 1'b0, 1'b0);
      for (int i = 0; i < n; i++) begin
         w[i] = shift_data_out;
         tick(1'b0, 1'b1, 1'b0, 1'b0);
      end
   endtask

   // Shift a full word in, LSB first, then ask for an update
   task automatic write_update(input logic [37:0] w);
      for (int i = 0; i < 38; i++) begin
         tick(1'b0, 1'b1, 1'b0, w[i]);
      end
      tick(1'b0, 1'b0, 1'b1, 1'b0);
   endtask

   // Core trigger held one cycle beyond the minimum
   task automatic pulse_strobe();
      @(posedge clk);
      core_reconfig_strobe <= 1'b1;
      repeat (remote_upgrade_pkg::CORE_STROBE_MIN_CYC + 1) @(posedge clk);
      core_reconfig_strobe <= 1'b0;
   endtask
endmodule
`default_nettype wire
